// file: trim_device.sv
`timescale 1ns/1ps
module trim_device #(
  parameter logic [10:0] TEMP_TRIM  = 11'h000,
  parameter logic [15:0] REFH_TRIM  = 16'h0000,
  parameter logic [7:0]  REFR_TRIM  = 8'h00,
  parameter logic [7:0]  FLASH_FILL = 8'hff
) (
  // Clock and reset
  input  wire logic REF_CLK,
  input  wire logic RESET_N,
  input  wire logic CLK_EN,
  // Link
  trim_if.device    LINK,
  // Engine view
  output logic [31:0] ACCUM_WORD,
  output logic [2:0]  ENGINE_EQUATION
);
  import trim_pkg::*;
  logic [7:0]  rdata_d, rdata_q;
  logic        valid_d, valid_q;
  logic [10:0] tb_d, tb_q;
  logic [3:0]  fr_d, fr_q;
  logic        tick_d, tick_q;
  logic [31:0] acc_d, acc_q;
  logic [2:0]  eq_d, eq_q;
  always_comb begin
    rdata_d = FLASH_FILL;
    valid_d = LINK.pm_rd;
    if (LINK.pm_rd && LINK.page_sel && LINK.pm_addr[15:10] == LINK.code_base) begin
      // Full page offset decode, so the upper part of the page does not alias the trims
      case (LINK.pm_addr[9:0])
        {2'h0, OFS_TEMP_HI}: rdata_d = {5'h00, TEMP_TRIM[10:8]};
        {2'h0, OFS_TEMP_LO}: rdata_d = TEMP_TRIM[7:0];
        {2'h0, OFS_REFH_HI}: rdata_d = REFH_TRIM[15:8];
        {2'h0, OFS_REFH_LO}: rdata_d = REFH_TRIM[7:0];
        {2'h0, OFS_REFR}:    rdata_d = REFR_TRIM;
        default:             rdata_d = 8'h00;
      endcase
    end
    tb_d   = tb_q;
    fr_d   = fr_q;
    tick_d = 1'b0;
    if (LINK.engine_en) begin
      if (tb_q == 11'(TB_DIV - 1)) begin
        tb_d = 11'h000;
        if (fr_q == 4'(FRAME_CYCLES - 1)) begin
          fr_d   = 4'h0;
          tick_d = 1'b1;
        end else begin
          fr_d = fr_q + 4'h1;
        end
      end else begin
        tb_d = tb_q + 11'h001;
      end
    end else begin
      tb_d = 11'h000;
      fr_d = 4'h0;
    end
    acc_d = {19'h00000, LINK.accum_count};
    eq_d  = LINK.eq_sel;
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 8'h00;
      valid_q <= 1'b0;
      tb_q    <= 11'h000;
      fr_q    <= 4'h0;
      tick_q  <= 1'b0;
      acc_q   <= 32'h00000000;
      eq_q    <= EQUATION_RST;
    end else if (CLK_EN) begin
      rdata_q <= rdata_d;
      valid_q <= valid_d;
      tb_q    <= tb_d;
      fr_q    <= fr_d;
      tick_q  <= tick_d;
      acc_q   <= acc_d;
      eq_q    <= eq_d;
    end
  end
  assign LINK.pm_rdata    = rdata_q;
  assign LINK.pm_valid    = valid_q;
  assign LINK.frame_tick  = tick_q;
  assign ACCUM_WORD       = acc_q;
  assign ENGINE_EQUATION  = eq_q;
endmodule : trim_device

// file: trim_host.sv
`timescale 1ns/1ps
module trim_host (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             IRQ,
  // Link
  trim_if.host             LINK
);
  import trim_pkg::*;
  typedef enum logic [2:0] {IDLE = 3'b001, FETCH = 3'b010, WAITR = 3'b100} state_t;
  state_t      st_d, st_q;
  logic        wr_d, wr_q, ph_d, ph_q;
  logic [7:0]  wa_d, wa_q;
  logic [31:0] hr_d, hr_q;
  logic        sel_d, sel_q, en_d, en_q;
  logic [5:0]  base_d, base_q;
  logic [2:0]  eq_d, eq_q;
  logic [1:0]  fl_d, fl_q;
  logic [3:0]  cf_d, cf_q;
  logic [12:0] acc_d, acc_q;
  logic [7:0]  fofs_d, fofs_q, res_d, res_q;
  logic [1:0]  stat_d, stat_q, mask_d, mask_q;
  logic        rd_d, rd_q, irq_d, irq_q, bad_cfg;
  logic [15:0] pa_d, pa_q;
  logic [31:0] dw_d, dw_q;
  logic        dmw_d, dmw_q;
  always_comb begin
    ph_d = HSEL && HREADY && HTRANS[1];
    wr_d = HWRITE;
    wa_d = HADDR[7:0];
    sel_d = sel_q; en_d = en_q; base_d = base_q; eq_d = eq_q;
    fl_d = fl_q; cf_d = cf_q; acc_d = acc_q; fofs_d = fofs_q;
    res_d = res_q; mask_d = mask_q; st_d = st_q; rd_d = 1'b0; pa_d = pa_q;
    dw_d = dw_q; dmw_d = 1'b0;
    stat_d = stat_q;
    // Eight bits so that no product wraps onto fourteen
    bad_cfg = ({6'h00, fl_q} + 8'h01) * {4'h0, cf_q} != 8'(CONV_PRODUCT);
    if (ph_q && wr_q) begin
      case (wa_q)
        REG_CTRL: begin
          en_d = HWDATA[0] && st_q == IDLE && !sel_q;
          eq_d = HWDATA[7:5];
          base_d = HWDATA[13:8];
          fl_d = HWDATA[17:16];
          cf_d = HWDATA[23:20];
        end
        REG_ACCUM:  acc_d = HWDATA[12:0];
        REG_FETCH:  fofs_d = HWDATA[7:0];
        REG_STATUS: stat_d = stat_q & ~HWDATA[1:0];
        REG_MASK:   mask_d = HWDATA[1:0];
        REG_WORD: begin
          dw_d = HWDATA;
          dmw_d = !en_q;
          pa_d = word_byte_addr(HWDATA[31:24], 2'h0);
        end
        default: ;
      endcase
    end
    case (st_q)
      IDLE: begin
        if (ph_q && wr_q && wa_q == REG_FETCH && !en_q) begin
          sel_d = 1'b1;
          rd_d = 1'b1;
          pa_d = pm_addr(base_q, {2'h0, HWDATA[7:0]});
          st_d = FETCH;
        end
      end
      FETCH: st_d = WAITR;
      WAITR: begin
        if (LINK.pm_valid) begin
          res_d = LINK.pm_rdata;
          sel_d = 1'b0;
          stat_d[0] = 1'b1;
          st_d = IDLE;
        end
      end
      default: st_d = IDLE;
    endcase
    if (en_q && bad_cfg) begin
      stat_d[1] = 1'b1;
    end
    if (LINK.frame_tick) begin
      stat_d[1] = stat_d[1] | bad_cfg;
    end
    irq_d = |(stat_d & mask_d);
    // Read data built from next values in the address phase, so HRDATA leaves a flop
    case (HADDR[7:0])
      REG_CTRL:   hr_d = {8'h00, cf_d, 2'h0, fl_d, 2'h0, base_d, eq_d, 4'h0, en_d};
      REG_ACCUM:  hr_d = {19'h00000, acc_d};
      REG_FETCH:  hr_d = {23'h000000, sel_d, fofs_d};
      REG_RESULT: hr_d = {24'h000000, res_d};
      REG_STATUS: hr_d = {30'h00000000, stat_d};
      REG_MASK:   hr_d = {30'h00000000, mask_d};
      default:    hr_d = 32'h00000000;
    endcase
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= IDLE; ph_q <= 1'b0; wr_q <= 1'b0; wa_q <= 8'h00; hr_q <= 32'h00000000;
      sel_q <= 1'b0; en_q <= 1'b0; base_q <= CODE_BASE_RST; eq_q <= EQUATION_RST;
      fl_q <= FILTER_LEN_RST; cf_q <= CONV_FRAME_RST; acc_q <= ACCUM_RST;
      fofs_q <= 8'h00; res_q <= 8'h00; stat_q <= 2'h0; mask_q <= 2'h0;
      rd_q <= 1'b0; irq_q <= 1'b0; pa_q <= 16'h0000; dw_q <= 32'h00000000; dmw_q <= 1'b0;
    end else if (CLK_EN) begin
      st_q <= st_d; ph_q <= ph_d; wr_q <= wr_d; wa_q <= wa_d; hr_q <= hr_d;
      sel_q <= sel_d; en_q <= en_d; base_q <= base_d; eq_q <= eq_d;
      fl_q <= fl_d; cf_q <= cf_d; acc_q <= acc_d;
      fofs_q <= fofs_d; res_q <= res_d; stat_q <= stat_d; mask_q <= mask_d;
      rd_q <= rd_d; irq_q <= irq_d; pa_q <= pa_d; dw_q <= dw_d; dmw_q <= dmw_d;
    end
  end
  assign HRDATA           = hr_q;
  assign HREADYOUT        = 1'b1;
  assign HRESP            = 1'b0;
  assign IRQ              = irq_q;
  assign LINK.page_sel    = sel_q;
  assign LINK.code_base   = base_q;
  assign LINK.pm_rd       = rd_q;
  assign LINK.pm_addr     = pa_q;
  assign LINK.eq_sel      = eq_q;
  assign LINK.engine_en   = en_q;
  assign LINK.accum_count = acc_q;
  assign LINK.filter_len  = fl_q;
  assign LINK.conv_frame  = cf_q;
  assign LINK.dm_wr       = dmw_q;
  assign LINK.dm_addr     = pa_q;
  assign LINK.dm_wdata    = dw_q[7:0];
endmodule : trim_host

// file: trim_if.sv
`timescale 1ns/1ps
interface trim_if;
  logic        page_sel;
  logic [5:0]  code_base;
  logic        pm_rd;
  logic [15:0] pm_addr;
  logic [7:0]  pm_rdata;
  logic        pm_valid;
  logic [2:0]  eq_sel;
  logic        engine_en;
  logic [12:0] accum_count;
  logic [1:0]  filter_len;
  logic [3:0]  conv_frame;
  logic        frame_tick;
  logic        dm_wr;
  logic [15:0] dm_addr;
  logic [7:0]  dm_wdata;
  modport device (input page_sel, code_base, pm_rd, pm_addr, eq_sel, engine_en, accum_count, filter_len,
                  conv_frame, dm_wr, dm_addr, dm_wdata, output pm_rdata, pm_valid, frame_tick);
  modport host (output page_sel, code_base, pm_rd, pm_addr, eq_sel, engine_en, accum_count, filter_len,
                conv_frame, dm_wr, dm_addr, dm_wdata, input pm_rdata, pm_valid, frame_tick);
endinterface : trim_if

// file: trim_monitor.sv
`timescale 1ns/1ps
module trim_monitor (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  // Link
  input wire logic        page_sel,
  input wire logic [5:0]  code_base,
  input wire logic        pm_rd,
  input wire logic [15:0] pm_addr,
  input wire logic [7:0]  pm_rdata,
  input wire logic        pm_valid,
  input wire logic [2:0]  eq_sel,
  input wire logic        engine_en,
  input wire logic [1:0]  filter_len,
  input wire logic [3:0]  conv_frame,
  input wire logic        frame_tick
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  a_fetch_in_page: assert property (pm_rd |-> page_sel) else $error("fetch outside page");
  a_fetch_base: assert property (pm_rd |-> pm_addr[15:10] == code_base) else $error("bad base");
  a_read_answered: assert property (pm_rd |=> pm_valid) else $error("no answer");
  a_answer_caused: assert property (pm_valid |-> $past(pm_rd)) else $error("stray answer");
  a_temp_justified: assert property (pm_valid && $past(pm_addr[9:0]) == 10'h090 |-> pm_rdata[7:3] == 5'h00)
    else $error("temp high byte not justified");
  // A page left open would shadow ordinary flash
  a_page_released: assert property (pm_valid |-> ##[1:2] !page_sel) else $error("page held");
  a_engine_apart: assert property (engine_en |-> !page_sel && !pm_rd) else $error("fetch while on");
  a_reset_defaults: assert property ($rose(RESET_N) |-> eq_sel == 3'h5 && filter_len == 2'h1
    && conv_frame == 4'h7) else $error("bad defaults");
  a_tick_engine: assert property (frame_tick |-> $past(engine_en)) else $error("frame tick while off");
endmodule : trim_monitor

// file: trim_page_and_engine_setup_tb_top.sv
`timescale 1ns/1ps
module trim_page_and_engine_setup_tb_top;
  import trim_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en  = 1'b1;
  logic        hsel    = 1'b1;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata, accum_word, rd;
  logic        hreadyout, hresp, irq;
  logic [2:0]  engine_equation;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  trim_if link ();
  trim_device #(.TEMP_TRIM(11'h5a3), .REFH_TRIM(16'hc35e), .REFR_TRIM(8'h9b)) u_trim_device (.REF_CLK(ref_clk),
    .RESET_N(reset_n), .CLK_EN(clk_en), .LINK(link), .ACCUM_WORD(accum_word), .ENGINE_EQUATION(engine_equation));
  trim_host u_trim_host (.REF_CLK(ref_clk), .RESET_N(reset_n), .CLK_EN(clk_en), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq), .LINK(link));
  trim_monitor u_trim_monitor (.REF_CLK(ref_clk), .RESET_N(reset_n), .page_sel(link.page_sel),
    .code_base(link.code_base), .pm_rd(link.pm_rd), .pm_addr(link.pm_addr), .pm_rdata(link.pm_rdata),
    .pm_valid(link.pm_valid), .eq_sel(link.eq_sel), .engine_en(link.engine_en), .filter_len(link.filter_len),
    .conv_frame(link.conv_frame), .frame_tick(link.frame_tick));
  always #10 ref_clk = ~ref_clk;
  task automatic give_verdict;
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    // Two frame periods of about 23k cycles each dominate the run
    if (cycles == 80000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1
  // Entered just after a rising edge, left just after one
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // Clears the done bit first, so an old result can never pass as the new one
  task automatic fetch(input logic [7:0] ofs, input logic [7:0] exp);
    bus(1'b1, REG_STATUS, 32'h1);
    bus(1'b1, REG_FETCH, {24'h0, ofs});
    rd = 32'h0;
    for (int i = 0; i < 10 && rd[0] !== 1'b1; i++) bus(1'b0, REG_STATUS, 32'h0);
    chk1(rd[0], 1'b1);
    chk32({16'h0, link.pm_addr}, 32'h0000002a * 32'h00000400 + {24'h0, ofs});
    bus(1'b0, REG_RESULT, 32'h0);
    chk32({24'h0, rd[7:0]}, {24'h0, exp});
  endtask : fetch
  task automatic t_defaults;
    bus(1'b0, REG_CTRL, 32'h0);
    chk32(rd, 32'h007100a0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk32(rd, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk32(rd, 32'h0);
  endtask : t_defaults
  task automatic t_trim;
    logic [7:0] ofs_t [6] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95};
    logic [7:0] exp_t [6] = '{8'h05, 8'ha3, 8'hc3, 8'h5e, 8'h9b, 8'h00};
    logic [7:0] hi;
    bus(1'b1, REG_CTRL, 32'h00712aa0);
    for (int i = 0; i < 6; i++) begin
      fetch(ofs_t[i], exp_t[i]);
      bus(1'b1, REG_STATUS, 32'h1);
      chk1(link.page_sel, 1'b0);
    end
    fetch(OFS_TEMP_HI, 8'h05);
    hi = rd[7:0];
    fetch(OFS_TEMP_LO, 8'ha3);
    chk32({16'h0, {5{hi[2]}}, hi[2:0], rd[7:0]}, 32'h0000fda3);
  endtask : t_trim
  task automatic t_irq;
    bus(1'b1, REG_MASK, 32'h1);
    fetch(8'h94, 8'h9b);
    chk1(irq, 1'b1);
    bus(1'b1, REG_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk1(irq, 1'b0);
    bus(1'b1, REG_MASK, 32'h1);
    bus(1'b1, REG_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk1(irq, 1'b0);
  endtask : t_irq
  // Counts cycles from one frame tick to the next
  task automatic t_frame;
    int n;
    n = 0;
    while (link.frame_tick !== 1'b1 && n < 30000) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    @(posedge ref_clk);
    while (link.frame_tick !== 1'b1 && n < 30000) begin
      @(posedge ref_clk);
      n++;
    end
    chk32(n + 1, FRAME_CYCLES * TB_DIV);
  endtask : t_frame
  task automatic t_engine;
    bus(1'b1, REG_ACCUM, 32'h00001abc);
    bus(1'b0, REG_ACCUM, 32'h0);
    chk32(rd, 32'h00001abc);
    bus(1'b1, REG_WORD, 32'h23000000);
    @(posedge ref_clk);
    chk1(link.dm_wr, 1'b1);
    chk32({16'h0, link.dm_addr}, 32'h0000008c);
    bus(1'b1, REG_CTRL, 32'h00710061);
    repeat (2) @(posedge ref_clk);
    chk32(accum_word, 32'h00001abc);
    chk32({29'h0, engine_equation}, 32'h3);
    t_frame();
    // A fetch now would steal program space from the running engine
    bus(1'b1, REG_FETCH, 32'h94);
    repeat (4) @(posedge ref_clk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk32({30'h0, rd[1:0]}, 32'h0);
    bus(1'b1, REG_WORD, 32'h24000000);
    @(posedge ref_clk);
    chk1(link.dm_wr, 1'b0);
    bus(1'b1, REG_CTRL, 32'h00510061);
    bus(1'b0, REG_STATUS, 32'h0);
    chk1(rd[1], 1'b1);
  endtask : t_engine
  // Writes while frozen or deselected must leave no trace
  task automatic t_gate;
    bus(1'b1, REG_MASK, 32'h0);
    clk_en <= 1'b0;
    bus(1'b1, REG_MASK, 32'h3);
    clk_en <= 1'b1;
    hsel   <= 1'b0;
    bus(1'b1, REG_MASK, 32'h3);
    hsel   <= 1'b1;
    bus(1'b0, REG_MASK, 32'h0);
    chk32(rd, 32'h0);
  endtask : t_gate
  task automatic t_reset;
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, REG_CTRL, 32'h0);
    chk32(rd, 32'h007100a0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk32(rd, 32'h0);
  endtask : t_reset
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_defaults();
    t_trim();
    t_irq();
    t_engine();
    t_gate();
    t_reset();
    give_verdict();
  end
endmodule : trim_page_and_engine_setup_tb_top

// file: trim_pkg.sv
package trim_pkg;
  localparam logic [7:0]  OFS_TEMP_HI       = 8'h90;
  localparam logic [7:0]  OFS_TEMP_LO       = 8'h91;
  localparam logic [7:0]  OFS_REFH_HI       = 8'h92;
  localparam logic [7:0]  OFS_REFH_LO       = 8'h93;
  localparam logic [7:0]  OFS_REFR          = 8'h94;
  localparam logic [7:0]  PHASE_ACCUM_COPY_WORD      = 8'h23;
  localparam int          FRAME_CYCLES      = 15;
  localparam int          CONV_PRODUCT      = 14;
  localparam logic [1:0]  FILTER_LEN_RST    = 2'h1;
  localparam logic [3:0]  CONV_FRAME_RST    = 4'h7;
  localparam logic [2:0]  EQUATION_RST      = 3'h5;
  localparam logic [12:0] ACCUM_RST         = 13'h0000;
  localparam logic [5:0]  CODE_BASE_RST     = 6'h00;
  localparam int          TIMEBASE_HZ       = 32768;
  localparam int          REF_HZ            = 50000000;
  localparam int          TB_DIV            = REF_HZ / TIMEBASE_HZ;
  // Bus register map
  localparam logic [7:0]  REG_CTRL          = 8'h00;
  localparam logic [7:0]  REG_ACCUM         = 8'h04;
  localparam logic [7:0]  REG_FETCH         = 8'h08;
  localparam logic [7:0]  REG_RESULT        = 8'h0c;
  localparam logic [7:0]  REG_STATUS        = 8'h10;
  localparam logic [7:0]  REG_MASK          = 8'h14;
  localparam logic [7:0]  REG_WORD          = 8'h18;
  function automatic logic [15:0] pm_addr(input logic [5:0] base, input logic [9:0] ofs);
    pm_addr = {base, ofs};
  endfunction : pm_addr
  function automatic logic [15:0] word_byte_addr(input logic [7:0] w, input logic [1:0] b);
    word_byte_addr = {6'h00, w, b};
  endfunction : word_byte_addr
endpackage : trim_pkg
